//--- hw/adc_ctrl_cfg.svh
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// register byte addresses
`define ADDR_TIMING 4'h0
`define ADDR_REFSAMP 4'h4
`define ADDR_TRIGSUSP 4'h8
`define ADDR_RESOLUTION 4'hC

// timing control fields
`define BIT_REF_READY_IE 15
`define BIT_REF_ERROR_IE 14
`define BIT_EARLY_IE 12
`define BIT_SEQ_REQ_EN 11
`define MASK_TIMING 16'hDF7F

// reference status / sample time fields
`define BIT_REF_READY 15
`define BIT_REF_ERROR 14
`define MASK_SAMPLE 16'h03FF

// trigger and suspend fields
`define BIT_SUSPEND 12
`define BIT_SUSP_IE 11
`define BIT_SUSPENDED 10
`define BIT_DIRECT_SAMP 9
`define BIT_INDIV_TRIG 8
`define BIT_LEVEL_TRIG 7
`define BIT_COMMON_TRIG 6
`define MASK_TRIGSUSP 16'hFBFF

// resolution register reset is 12-bit
`define RESOLUTION_RESET 2'h3

`endif

//--- hw/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    // shared core sequencing states, gray from idle to sample to convert
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11
    } core_state_t;
    typedef enum logic [1:0]
    {
        RES_6 = 2'b00,
        RES_8 = 2'b01,
        RES_10 = 2'b10,
        RES_12 = 2'b11
    } resolution_t;
endpackage : adc_ctrl_pkg

//--- hw/adc_shared_core_trigger_control.sv
// Summary of operation
// - ready enable raises common irq on ready
// - error enable raises common irq on error
// - channel irq from early or ready flag
// - sequencer requests pass only when enabled
// - early flag n+1 core clocks before data
// - core period is twice divider, minimum two
// - sample time is field plus two periods
// - ready flag mirrors band gap ready
// - error flag sets on loss while enabled
// - suspend blocks all new triggers
// - suspended flag when suspend and idle
// - suspend enable raises irq when suspended
// - direct sampling holds selected channel sampling
// - individual trigger bit self-clears after pulse
// - level trigger fires continuously while set
// - common trigger bit single pulse, self-clears
// - channel select names individual trigger channel
// - unimplemented bits read zero, ignore writes
// - resolution codes select 12/10/8/6 bits
// - source clock divides into core clock
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"

module adc_shared_core_trigger_control #(
    parameter int CONV_BITS_12 = 13
)(
    // clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // avalon-mm slave
    input wire logic [3:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [3:0] BYTEENABLE,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // analog side status (asynchronous)
    input wire logic BANDGAP_READY,
    input wire logic MODULE_ENABLE,
    input wire logic [23:0] CHANNEL_EARLY_FLAG,
    input wire logic [23:0] CHANNEL_RESULT_READY,
    input wire logic DEDICATED_BUSY,
    // sequencer request (same clock)
    input wire logic SEQ_REQUEST,
    // trigger and core outputs
    output logic [23:0] CHANNEL_IRQ,
    output logic COMMON_IRQ,
    output logic INDIV_TRIGGER,
    output logic COMMON_TRIGGER,
    output logic LEVEL_TRIGGER,
    output logic SEQ_TRIGGER,
    output logic [5:0] TRIGGER_CHANNEL,
    output logic DIRECT_SAMPLING,
    output logic [2:0] REFERENCE_SELECT,
    output logic CORE_CLOCK_TICK,
    output logic CORE_SAMPLING,
    output logic CORE_EARLY,
    output logic CORE_DATA_READY
);

    logic [15:0] timing_reg;
    logic [9:0] sample_time;
    logic [15:0] trig_reg;
    logic [1:0] resolution;
    logic ref_error;
    logic [1:0] sync_ready;
    logic [1:0] sync_enable;
    logic [1:0] sync_busy;
    logic [23:0] sync_early_a;
    logic [23:0] sync_early;
    logic [23:0] sync_rdy_a;
    logic [23:0] sync_rdy;
    logic [23:0] rdy_prev;
    logic susp_prev;
    logic ready_prev;
    logic irq_pending;
    logic [7:0] div_count;
    logic [10:0] phase_count;
    adc_ctrl_pkg::core_state_t state;
    logic [15:0] wr_lo;

    // bus decode; every access answers in the same cycle
    wire wr_timing = WRITE && ADDRESS == `ADDR_TIMING;
    wire wr_refsamp = WRITE && ADDRESS == `ADDR_REFSAMP;
    wire wr_trig = WRITE && ADDRESS == `ADDR_TRIGSUSP;
    wire wr_res = WRITE && ADDRESS == `ADDR_RESOLUTION;
    assign WAITREQUEST = 1'b0;

    // byte-lane merge on the low half-word
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] be);
        merge = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    endfunction : merge

    always_comb
    begin
        wr_lo = 16'h0000;
        if (wr_timing)
            wr_lo = merge(timing_reg, WRITEDATA[15:0], BYTEENABLE[1:0]);
        else if (wr_refsamp)
            wr_lo = merge({6'h00, sample_time}, WRITEDATA[15:0], BYTEENABLE[1:0]);
        else if (wr_trig)
            wr_lo = merge(trig_reg, WRITEDATA[15:0], BYTEENABLE[1:0]);
        else if (wr_res)
            wr_lo = merge({14'h0000, resolution}, WRITEDATA[15:0], BYTEENABLE[1:0]);
    end

    // status synchronisers, two stages each
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync_ready <= 2'h0;
            sync_enable <= 2'h0;
            sync_busy <= 2'h0;
            sync_early_a <= 24'h000000;
            sync_early <= 24'h000000;
            sync_rdy_a <= 24'h000000;
            sync_rdy <= 24'h000000;
        end
        else
        begin
            sync_ready <= {sync_ready[0], BANDGAP_READY};
            sync_enable <= {sync_enable[0], MODULE_ENABLE};
            sync_busy <= {sync_busy[0], DEDICATED_BUSY};
            sync_early_a <= CHANNEL_EARLY_FLAG;
            sync_early <= sync_early_a;
            sync_rdy_a <= CHANNEL_RESULT_READY;
            sync_rdy <= sync_rdy_a;
        end
    end

    wire ref_ready = sync_ready[1];
    wire suspended = trig_reg[`BIT_SUSPEND] && !sync_busy[1] && state == adc_ctrl_pkg::ST_IDLE;
    wire trig_gate = !trig_reg[`BIT_SUSPEND];

    // software registers; unimplemented bits masked out
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            timing_reg <= 16'h0000;
            sample_time <= 10'h000;
            trig_reg <= 16'h0000;
            resolution <= `RESOLUTION_RESET;
        end
        else
        begin
            if (wr_timing)
                timing_reg <= wr_lo & `MASK_TIMING;
            if (wr_refsamp)
                sample_time <= wr_lo[9:0];
            if (wr_res)
                resolution <= wr_lo[1:0];
            if (wr_trig)
                trig_reg <= wr_lo & `MASK_TRIGSUSP;
            else
                trig_reg <= trig_reg & ~16'h0140; // one-cycle self-clear
        end
    end

    // reference error latches on loss while enabled; cleared when module disabled
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ref_error <= 1'b0;
            ready_prev <= 1'b0;
            susp_prev <= 1'b0;
            rdy_prev <= 24'h000000;
        end
        else
        begin
            ready_prev <= ref_ready;
            susp_prev <= suspended;
            rdy_prev <= sync_rdy;
            if (sync_enable[1] && ready_prev && !ref_ready)
                ref_error <= 1'b1;
            else if (!sync_enable[1])
                ref_error <= 1'b0;
        end
    end

    // common interrupt events, one-cycle pulses
    wire ev_ready = timing_reg[`BIT_REF_READY_IE] && ref_ready && !ready_prev;
    wire ev_error = timing_reg[`BIT_REF_ERROR_IE] && sync_enable[1] && ready_prev && !ref_ready;
    wire ev_susp = trig_reg[`BIT_SUSP_IE] && suspended && !susp_prev;

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            irq_pending <= 1'b0;
        else
            irq_pending <= ev_ready || ev_error || ev_susp;
    end
    assign COMMON_IRQ = irq_pending;

    // per-channel interrupt source select
    genvar g;
    generate
        for (g = 0; g < 24; g++)
        begin : g_chan
            assign CHANNEL_IRQ[g] = timing_reg[`BIT_EARLY_IE] ? sync_early[g] : (sync_rdy[g] && !rdy_prev[g]);
        end
    endgenerate

    // trigger outputs, the four trigger pulses gated by suspend
    assign INDIV_TRIGGER = trig_reg[`BIT_INDIV_TRIG] && trig_gate;
    assign COMMON_TRIGGER = trig_reg[`BIT_COMMON_TRIG] && trig_gate;
    assign LEVEL_TRIGGER = trig_reg[`BIT_LEVEL_TRIG] && trig_gate;
    assign SEQ_TRIGGER = SEQ_REQUEST && timing_reg[`BIT_SEQ_REQ_EN] && trig_gate;
    assign TRIGGER_CHANNEL = trig_reg[5:0];
    assign DIRECT_SAMPLING = trig_reg[`BIT_DIRECT_SAMP];
    assign REFERENCE_SELECT = trig_reg[15:13];

    // accepted trigger restarts the divider, so sampling spans whole core periods
    wire start = (INDIV_TRIGGER || COMMON_TRIGGER || LEVEL_TRIGGER || SEQ_TRIGGER) && !DIRECT_SAMPLING;
    wire restart = start && state == adc_ctrl_pkg::ST_IDLE;

    // core clock divider: period 2*max(field,1) source cycles
    wire [7:0] div_period = (timing_reg[6:0] < 7'h02) ? 8'h02 : {timing_reg[6:0], 1'b0};
    wire tick = div_count == div_period - 8'h01;
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
            div_count <= 8'h00;
        else
            div_count <= (tick || restart) ? 8'h00 : div_count + 8'h01;
    end
    assign CORE_CLOCK_TICK = tick;

    // conversion length in core clocks by resolution
    wire [10:0] conv_len = 11'(CONV_BITS_12) - {8'h00, (~resolution), 1'b0};
    wire [10:0] sample_len = {1'b0, sample_time} + 11'h002;

    // shared core sequencer: sample, then convert
    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state <= adc_ctrl_pkg::ST_IDLE;
            phase_count <= 11'h000;
        end
        else
        begin
            case (state)
                adc_ctrl_pkg::ST_IDLE:
                    if (start)
                    begin
                        state <= adc_ctrl_pkg::ST_SAMPLE;
                        phase_count <= 11'h000;
                    end
                adc_ctrl_pkg::ST_SAMPLE:
                    if (tick)
                    begin
                        if (phase_count == sample_len - 11'h001)
                        begin
                            state <= adc_ctrl_pkg::ST_CONVERT;
                            phase_count <= 11'h000;
                        end
                        else
                            phase_count <= phase_count + 11'h001;
                    end
                adc_ctrl_pkg::ST_CONVERT:
                    if (tick)
                    begin
                        if (phase_count == conv_len - 11'h001)
                            state <= adc_ctrl_pkg::ST_IDLE;
                        else
                            phase_count <= phase_count + 11'h001;
                    end
                default:
                    state <= adc_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    // early flag n+1 core clocks before data ready
    wire [10:0] early_at = conv_len - {7'h00, 1'b0, timing_reg[10:8]} - 11'h001;
    assign CORE_SAMPLING = state == adc_ctrl_pkg::ST_SAMPLE || DIRECT_SAMPLING;
    assign CORE_EARLY = state == adc_ctrl_pkg::ST_CONVERT && tick && phase_count == early_at - 11'h001;
    assign CORE_DATA_READY = state == adc_ctrl_pkg::ST_CONVERT && tick && phase_count == conv_len - 11'h001;

    // register read mux
    always_comb
    begin
        READDATA = 32'h00000000;
        case (ADDRESS)
            `ADDR_TIMING: READDATA[15:0] = timing_reg;
            `ADDR_REFSAMP: READDATA[15:0] = {ref_ready, ref_error, 4'h0, sample_time};
            `ADDR_TRIGSUSP: READDATA[15:0] = {trig_reg[15:11], suspended, trig_reg[9:0]};
            `ADDR_RESOLUTION: READDATA[1:0] = resolution;
            default: READDATA = 32'h00000000;
        endcase
    end

    // assertions
    property p_sw_pulse;
        @(posedge MCLK) disable iff (!RESETN)
        trig_reg[`BIT_COMMON_TRIG] |=> !trig_reg[`BIT_COMMON_TRIG] || $past(wr_trig);
    endproperty
    a_sw_pulse: assert property (p_sw_pulse) else $error("common trigger held");

    property p_suspend_block;
        @(posedge MCLK) disable iff (!RESETN)
        trig_reg[`BIT_SUSPEND] |-> !(INDIV_TRIGGER || COMMON_TRIGGER || LEVEL_TRIGGER || SEQ_TRIGGER);
    endproperty
    a_suspend_block: assert property (p_suspend_block) else $error("trigger while suspended");

    property p_seq_gate;
        @(posedge MCLK) disable iff (!RESETN)
        SEQ_TRIGGER |-> timing_reg[`BIT_SEQ_REQ_EN];
    endproperty
    a_seq_gate: assert property (p_seq_gate) else $error("sequencer request not enabled");

    property p_susp_irq;
        @(posedge MCLK) disable iff (!RESETN)
        (trig_reg[`BIT_SUSP_IE] && suspended && !susp_prev) |=> COMMON_IRQ;
    endproperty
    a_susp_irq: assert property (p_susp_irq) else $error("suspend irq missing");

    property p_div_period;
        @(posedge MCLK) disable iff (!RESETN)
        (tick && $stable(timing_reg)) |-> div_count == div_period - 8'h01 && div_period >= 8'h02;
    endproperty
    a_div_period: assert property (p_div_period) else $error("core clock period wrong");

    property p_suspended;
        @(posedge MCLK) disable iff (!RESETN)
        suspended |-> state == adc_ctrl_pkg::ST_IDLE && trig_reg[`BIT_SUSPEND];
    endproperty
    a_suspended: assert property (p_suspended) else $error("suspended while busy");

    property p_ref_irq;
        @(posedge MCLK) disable iff (!RESETN)
        $rose(ref_ready) && timing_reg[`BIT_REF_READY_IE] |=> COMMON_IRQ;
    endproperty
    a_ref_irq: assert property (p_ref_irq) else $error("ready irq missing");

    property p_ref_err;
        @(posedge MCLK) disable iff (!RESETN)
        (sync_enable[1] && $fell(ref_ready)) |=> ref_error;
    endproperty
    a_ref_err: assert property (p_ref_err) else $error("error flag not set");

    property p_indiv_pulse;
        @(posedge MCLK) disable iff (!RESETN)
        INDIV_TRIGGER |=> !INDIV_TRIGGER || $past(wr_trig);
    endproperty
    a_indiv_pulse: assert property (p_indiv_pulse) else $error("individual trigger held");

    property p_err_irq;
        @(posedge MCLK) disable iff (!RESETN)
        (timing_reg[`BIT_REF_ERROR_IE] && sync_enable[1] && $fell(ref_ready)) |=> COMMON_IRQ;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error irq missing");

    property p_start_samples;
        @(posedge MCLK) disable iff (!RESETN)
        restart |=> CORE_SAMPLING;
    endproperty
    a_start_samples: assert property (p_start_samples) else $error("trigger did not start sampling");

    property p_ready_ends;
        @(posedge MCLK) disable iff (!RESETN)
        CORE_DATA_READY |=> state == adc_ctrl_pkg::ST_IDLE;
    endproperty
    a_ready_ends: assert property (p_ready_ends) else $error("core busy after data ready");

endmodule : adc_shared_core_trigger_control
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_cfg.svh"

module tb;
    // clock, reset and bus
    logic MCLK = 1'b0;
    logic RESETN = 1'b0;
    logic [3:0] ADDRESS = 4'h0;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [3:0] BYTEENABLE = 4'h3;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    // analog side and sequencer
    logic BANDGAP_READY = 1'b0;
    logic MODULE_ENABLE = 1'b0;
    logic [23:0] CHANNEL_EARLY_FLAG = 24'h0;
    logic [23:0] CHANNEL_RESULT_READY = 24'h0;
    logic DEDICATED_BUSY = 1'b0;
    logic SEQ_REQUEST = 1'b0;
    // observed outputs
    logic [23:0] CHANNEL_IRQ;
    logic COMMON_IRQ, INDIV_TRIGGER, COMMON_TRIGGER, LEVEL_TRIGGER, SEQ_TRIGGER;
    logic [5:0] TRIGGER_CHANNEL;
    logic DIRECT_SAMPLING, CORE_CLOCK_TICK, CORE_SAMPLING, CORE_EARLY, CORE_DATA_READY;
    logic [2:0] REFERENCE_SELECT;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    int irq_cnt, ctrg_cnt, itrg_cnt, ch3_cnt, samp_len, rdy_cnt, t_early, t_ready, t_tick, tick_len, t_trig;
    logic [15:0] rv;

    adc_shared_core_trigger_control #(.CONV_BITS_12(13)) uut (.MCLK(MCLK), .RESETN(RESETN),
        .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE),
        .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .BANDGAP_READY(BANDGAP_READY),
        .MODULE_ENABLE(MODULE_ENABLE), .CHANNEL_EARLY_FLAG(CHANNEL_EARLY_FLAG),
        .CHANNEL_RESULT_READY(CHANNEL_RESULT_READY), .DEDICATED_BUSY(DEDICATED_BUSY),
        .SEQ_REQUEST(SEQ_REQUEST), .CHANNEL_IRQ(CHANNEL_IRQ), .COMMON_IRQ(COMMON_IRQ),
        .INDIV_TRIGGER(INDIV_TRIGGER), .COMMON_TRIGGER(COMMON_TRIGGER), .LEVEL_TRIGGER(LEVEL_TRIGGER),
        .SEQ_TRIGGER(SEQ_TRIGGER), .TRIGGER_CHANNEL(TRIGGER_CHANNEL), .DIRECT_SAMPLING(DIRECT_SAMPLING),
        .REFERENCE_SELECT(REFERENCE_SELECT), .CORE_CLOCK_TICK(CORE_CLOCK_TICK),
        .CORE_SAMPLING(CORE_SAMPLING), .CORE_EARLY(CORE_EARLY), .CORE_DATA_READY(CORE_DATA_READY));

    // 200 MHz clock
    always #2.5 MCLK = ~MCLK;

    // event counters and timestamps; pulses are counted per cycle so a stretched pulse shows up
    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        if (COMMON_IRQ === 1'b1) irq_cnt <= irq_cnt + 1;
        if (COMMON_TRIGGER === 1'b1) ctrg_cnt <= ctrg_cnt + 1;
        if (INDIV_TRIGGER === 1'b1) itrg_cnt <= itrg_cnt + 1;
        if (INDIV_TRIGGER === 1'b1) t_trig <= cyc;
        if (CHANNEL_IRQ[3] === 1'b1) ch3_cnt <= ch3_cnt + 1;
        if (CORE_SAMPLING === 1'b1) samp_len <= samp_len + 1;
        if (CORE_EARLY === 1'b1) t_early <= cyc;
        if (CORE_DATA_READY === 1'b1) t_ready <= cyc;
        if (CORE_DATA_READY === 1'b1) rdy_cnt <= rdy_cnt + 1;
        if (CORE_CLOCK_TICK === 1'b1) tick_len <= cyc - t_tick;
        if (CORE_CLOCK_TICK === 1'b1) t_tick <= cyc;
        // hang guard well above the expected run length
        if (cyc == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    task automatic stop_test();
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            n_mismatch = n_mismatch + 1;
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge MCLK);
    endtask : idle

    task automatic clr();
        @(posedge MCLK);
        irq_cnt = 0; ctrg_cnt = 0; itrg_cnt = 0; ch3_cnt = 0; samp_len = 0; rdy_cnt = 0;
    endtask : clr

    // bus cycle: request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge MCLK);
        ADDRESS <= a;
        WRITE <= wr;
        READ <= ~wr;
        WRITEDATA <= {16'h0000, d};
        do @(posedge MCLK); while (WAITREQUEST !== 1'b0);
        q = READDATA[15:0];
        WRITE <= 1'b0;
        READ <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string what, input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(what, {16'h0000, q}, {16'h0000, exp});
    endtask : rd_chk

    // one shared-core conversion; all timings follow from divider, lead code, sample field and resolution
    task automatic run_core(input int div, input int sel, input int smp, input logic [5:0] ch, input int res);
        int per;
        per = (div < 2) ? 2 : 2 * div;
        wr(`ADDR_TIMING, 16'(sel << 8) | 16'(div));
        wr(`ADDR_REFSAMP, 16'(smp));
        wr(`ADDR_RESOLUTION, 16'(res));
        clr();
        wr(`ADDR_TRIGSUSP, 16'h0100 | {10'h000, ch});
        for (int i = 0; i < 3000 && rdy_cnt == 0; i++) @(posedge MCLK);
        idle(2);
        chk("indiv pulses", itrg_cnt, 1);
        chk("trig chan", {26'h0, TRIGGER_CHANNEL}, {26'h0, ch});
        chk("core period", tick_len, per);
        chk("sample len", samp_len, (smp + 2) * per);
        chk("early lead", t_ready - t_early, (sel + 1) * per);
        chk("conv len", t_ready - t_trig, (smp + 2 + 13 - 2 * (3 - res)) * per);
        rd_chk("indiv selfclr", `ADDR_TRIGSUSP, {10'h000, ch});
    endtask : run_core

    initial
    begin
        idle(3);
        RESETN <= 1'b1;
        // reset values
        rd_chk("timing rst", `ADDR_TIMING, 16'h0000);
        rd_chk("refsamp rst", `ADDR_REFSAMP, 16'h0000);
        rd_chk("trig rst", `ADDR_TRIGSUSP, 16'h0000);
        rd_chk("res rst", `ADDR_RESOLUTION, 16'h0003);
        // unimplemented bits and unmapped place
        wr(`ADDR_TIMING, 16'hFFFF);
        rd_chk("timing mask", `ADDR_TIMING, 16'hDF7F);
        wr(`ADDR_REFSAMP, 16'hFFFF);
        rd_chk("refsamp mask", `ADDR_REFSAMP, 16'h03FF);
        wr(4'h2, 16'hFFFF);
        rd_chk("unmapped", 4'h2, 16'h0000);
        wr(`ADDR_REFSAMP, 16'h0000);
        // reference ready and loss with their common interrupts
        wr(`ADDR_TIMING, 16'hC000);
        clr();
        BANDGAP_READY <= 1'b1;
        idle(10);
        chk("ready irq", irq_cnt, 1);
        rd_chk("ready flag", `ADDR_REFSAMP, 16'h8000);
        MODULE_ENABLE <= 1'b1; // configured before enabling
        idle(6);
        clr();
        BANDGAP_READY <= 1'b0;
        idle(10);
        chk("error irq", irq_cnt, 1);
        rd_chk("error flag", `ADDR_REFSAMP, 16'h4000);
        MODULE_ENABLE <= 1'b0;
        BANDGAP_READY <= 1'b1;
        wr(`ADDR_TIMING, 16'h0000);
        idle(6);
        // sequencer request gating
        SEQ_REQUEST <= 1'b1;
        idle(2);
        chk("seq off", SEQ_TRIGGER, 1'b0);
        wr(`ADDR_TIMING, 16'h0800);
        idle(1);
        chk("seq on", SEQ_TRIGGER, 1'b1);
        SEQ_REQUEST <= 1'b0;
        // channel interrupt: done-based, then early-based
        wr(`ADDR_TIMING, 16'h0000);
        clr();
        CHANNEL_RESULT_READY[3] <= 1'b1;
        idle(8);
        chk("done irq", ch3_cnt, 1);
        CHANNEL_RESULT_READY <= 24'h0;
        wr(`ADDR_TIMING, 16'h1000);
        CHANNEL_EARLY_FLAG[5] <= 1'b1;
        idle(6);
        chk("early irq", CHANNEL_IRQ[5], 1'b1);
        CHANNEL_EARLY_FLAG <= 24'h0;
        idle(6);
        chk("early irq off", CHANNEL_IRQ[5], 1'b0);
        // common single trigger, back to back writes
        clr();
        wr(`ADDR_TRIGSUSP, 16'h0040);
        wr(`ADDR_TRIGSUSP, 16'h0040);
        // the first pulse starts a conversion; let it drain before later triggers
        idle(40);
        chk("common pulses", ctrg_cnt, 2);
        rd_chk("common selfclr", `ADDR_TRIGSUSP, 16'h0000);
        // level trigger and direct sampling stay while set
        wr(`ADDR_TRIGSUSP, 16'h02AA);
        idle(8);
        chk("level trig", LEVEL_TRIGGER, 1'b1);
        chk("direct samp", DIRECT_SAMPLING, 1'b1);
        rd_chk("direct kept", `ADDR_TRIGSUSP, 16'h02AA);
        wr(`ADDR_TRIGSUSP, 16'h0000);
        idle(2);
        chk("level off", LEVEL_TRIGGER, 1'b0);
        // shared core timing at three divider settings
        run_core(1, 2, 1, 6'h25, 3);
        run_core(3, 0, 0, 6'h01, 1); // lead code valid at 8 bits
        run_core(0, 7, 2, 6'h3F, 3); // widest lead, valid from 8 bits up
        // suspend: flag waits for the dedicated core, then irq, then triggers ignored
        DEDICATED_BUSY <= 1'b1;
        clr();
        wr(`ADDR_TRIGSUSP, 16'h1800);
        idle(6);
        rd_chk("susp busy", `ADDR_TRIGSUSP, 16'h1800);
        chk("susp no irq", irq_cnt, 0);
        DEDICATED_BUSY <= 1'b0;
        idle(8);
        rd_chk("suspended", `ADDR_TRIGSUSP, 16'h1C00);
        chk("susp irq", irq_cnt, 1);
        wr(`ADDR_TRIGSUSP, 16'h1940);
        idle(4);
        chk("susp common", ctrg_cnt, 0);
        chk("susp indiv", itrg_cnt, 0);
        wr(`ADDR_TRIGSUSP, 16'h0000);
        idle(6);
        rd_chk("resume", `ADDR_TRIGSUSP, 16'h0000);
        chk("ref select", {29'h0, REFERENCE_SELECT}, 32'h0);
        stop_test();
    end
endmodule : tb
`default_nettype wire
